// ==== hw/cif_regs.svh ====
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH

// ==========================================================================
// register indices; the byte address on the bus is four times the index
// ==========================================================================
`define CIF_IDX_ENABLE 30'h0000_002b
`define CIF_IDX_FLAGS 30'h0000_002c

// ==========================================================================
// reset values
// ==========================================================================
`define CIF_ENABLE_RST 8'h00
`define CIF_FLAGS_RST 8'h00
`define CIF_RDATA_RST 32'h0000_0000

// ==========================================================================
// field positions, shared by the enable and the flag register
// ==========================================================================
`define CIF_BIT_MSG_ERR 7
`define CIF_BIT_WAKEUP 6
`define CIF_BIT_ERR_CHG 5
`define CIF_BIT_TX2 4
`define CIF_BIT_TX1 3
`define CIF_BIT_TX0 2
`define CIF_BIT_RX1 1
`define CIF_BIT_RX0 0

// ==========================================================================
// bus encodings
// ==========================================================================
`define CIF_HTRANS_NONSEQ 2'h2
`define CIF_HRESP_OKAY 1'h0

`endif

// ==== hw/cif_pkg.sv ====
`default_nettype none

package cif_pkg;

  // ========================================================================
  // register selected by a bus transfer
  // ========================================================================
  typedef enum logic [1:0] {
    CIF_SEL_NONE = 2'h0,
    CIF_SEL_ENABLE = 2'h1,
    CIF_SEL_FLAGS = 2'h3
  } cif_sel_t;

  // ========================================================================
  // state of the bus front end
  // ========================================================================
  typedef struct packed {
    logic wr_pend;
    cif_sel_t wr_sel;
    logic readyout;
    logic resp;
  } cif_front_t;

  // ========================================================================
  // state of the event capture
  // ========================================================================
  typedef struct packed {
    logic [7:0] err_prev;
  } cif_evt_t;

  // ========================================================================
  // state of the register core
  // ========================================================================
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] flags;
    logic irq;
    logic [31:0] rdata;
  } cif_core_t;

endpackage

`default_nettype wire

// ==== hw/cif_ahb_front.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cif_regs.svh"

module cif_ahb_front import cif_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wr_en,
  output cif_sel_t wr_sel,
  output cif_sel_t rd_sel
);

  cif_front_t st_ff;
  cif_front_t nxt_st;
  logic take;
  cif_sel_t addr_sel;

  // ========================================================================
  // address phase decode
  // ========================================================================
  // only NONSEQ is taken: the master issues single word transfers
  assign take = hsel & hready & (htrans == `CIF_HTRANS_NONSEQ);

  always_comb begin
    case (haddr[31:2])
      `CIF_IDX_ENABLE: addr_sel = CIF_SEL_ENABLE;
      `CIF_IDX_FLAGS: addr_sel = CIF_SEL_FLAGS;
      default: addr_sel = CIF_SEL_NONE; // unmapped: reads zero, writes dropped
    endcase
  end

  // ========================================================================
  // data phase tracking; no wait states, so hreadyout is always high
  // ========================================================================
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_pend = take & hwrite;
    nxt_st.wr_sel = (take & hwrite) ? addr_sel : CIF_SEL_NONE;
    nxt_st.readyout = 1'b1;
    nxt_st.resp = `CIF_HRESP_OKAY;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{wr_pend: 1'b0, wr_sel: CIF_SEL_NONE, readyout: 1'b1, resp: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = st_ff.readyout;
  assign hresp = st_ff.resp;
  assign wr_en = st_ff.wr_pend;
  assign wr_sel = st_ff.wr_sel;
  // read data is prepared in the address phase so it can leave a flip-flop
  assign rd_sel = (take & ~hwrite) ? addr_sel : CIF_SEL_NONE;

endmodule

`default_nettype wire

// ==== hw/cif_evt_capture.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cif_regs.svh"

module cif_evt_capture import cif_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] error_condition_register,
  input wire logic message_error_evt,
  input wire logic wakeup_evt,
  input wire logic [2:0] tx_buf_empty_evt,
  input wire logic [1:0] rx_buf_full_evt,
  output logic [7:0] flag_set
);

  cif_evt_t st_ff;
  cif_evt_t nxt_st;

  // ========================================================================
  // error condition history; any bit turning either way is a change
  // ========================================================================
  always_comb begin
    nxt_st = st_ff;
    nxt_st.err_prev = error_condition_register;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{err_prev: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // set requests in flag register layout
  assign flag_set[`CIF_BIT_MSG_ERR] = message_error_evt;
  assign flag_set[`CIF_BIT_WAKEUP] = wakeup_evt;
  assign flag_set[`CIF_BIT_ERR_CHG] = |(error_condition_register ^ st_ff.err_prev);
  assign flag_set[`CIF_BIT_TX2:`CIF_BIT_TX0] = tx_buf_empty_evt;
  assign flag_set[`CIF_BIT_RX1:`CIF_BIT_RX0] = rx_buf_full_evt;

endmodule

`default_nettype wire

// ==== hw/cif_irq_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cif_regs.svh"

module cif_irq_top import cif_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] error_condition_register,
  input wire logic message_error_evt,
  input wire logic wakeup_evt,
  input wire logic [2:0] tx_buf_empty_evt,
  input wire logic [1:0] rx_buf_full_evt,
  output logic irq
);

  cif_core_t st_ff;
  cif_core_t nxt_st;
  logic wr_en;
  cif_sel_t wr_sel;
  cif_sel_t rd_sel;
  logic [7:0] flag_set;
  logic wr_enable;
  logic wr_flags;

  // ==========================================================================
  // bus front end
  // ==========================================================================
  cif_ahb_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .rd_sel(rd_sel)
  );

  // ==========================================================================
  // event capture
  // ==========================================================================
  cif_evt_capture u_evt (
    .hclk(hclk),
    .hresetn(hresetn),
    .error_condition_register(error_condition_register),
    .message_error_evt(message_error_evt),
    .wakeup_evt(wakeup_evt),
    .tx_buf_empty_evt(tx_buf_empty_evt),
    .rx_buf_full_evt(rx_buf_full_evt),
    .flag_set(flag_set)
  );

  // ==========================================================================
  // register core
  // ==========================================================================
  // write strobes in the data phase, when hwdata is valid
  assign wr_enable = wr_en & (wr_sel == CIF_SEL_ENABLE);
  assign wr_flags = wr_en & (wr_sel == CIF_SEL_FLAGS);

  // next state: software writes first, hardware sets on top so a set wins
  always_comb begin
    nxt_st = st_ff;
    if (wr_enable) begin
      nxt_st.enable = hwdata[7:0];
    end
    if (wr_flags) begin
      // a zero clears, a one may set a flag by software for test
      nxt_st.flags = hwdata[7:0];
    end
    // flags are sticky; only the write above removes them
    nxt_st.flags = nxt_st.flags | flag_set;
    // one gated or-tree serves every source alike
    nxt_st.irq = |(nxt_st.flags & nxt_st.enable);
    // read data reflects the state after this edge, so a read right after
    // a write sees the written value
    case (rd_sel)
      CIF_SEL_ENABLE: nxt_st.rdata = {24'h00_0000, nxt_st.enable};
      CIF_SEL_FLAGS: nxt_st.rdata = {24'h00_0000, nxt_st.flags};
      default: nxt_st.rdata = `CIF_RDATA_RST;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{enable: `CIF_ENABLE_RST, flags: `CIF_FLAGS_RST, irq: 1'b0, rdata: `CIF_RDATA_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs leave flip-flops directly
  assign hrdata = st_ff.rdata;
  assign irq = st_ff.irq;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // a write to the enable register lands one edge later
  sequence s_enable_write;
    wr_enable;
  endsequence

  property p_enable_write;
    s_enable_write |=> (st_ff.enable == $past(hwdata[7:0]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable register did not take written value");

  // error change with its enable set raises the interrupt next edge
  sequence s_err_change_armed;
    flag_set[`CIF_BIT_ERR_CHG] && st_ff.enable[`CIF_BIT_ERR_CHG] && !wr_enable;
  endsequence

  property p_err_irq;
    s_err_change_armed |=> irq;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("error change did not raise interrupt");

  // with no source enabled the interrupt stays low
  property p_err_masked;
    (st_ff.enable == 8'h00) |-> !irq;
  endproperty
  a_err_masked: assert property (p_err_masked)
    else $error("interrupt high with all sources disabled");

  // transmit empty events with enable raise the interrupt and hold it
  sequence s_tx_armed;
    (|(flag_set[`CIF_BIT_TX2:`CIF_BIT_TX0] & st_ff.enable[`CIF_BIT_TX2:`CIF_BIT_TX0]))
      && !wr_enable && !wr_flags;
  endsequence

  sequence s_held_two;
    irq [*2];
  endsequence

  property p_tx_irq;
    s_tx_armed ##1 (!wr_enable && !wr_flags) |-> ##1 irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit empty event did not hold interrupt");

  // a change on the error condition input sets flag bit 5; history restarts at reset
  property p_err_flag;
    $past(hresetn) && !$stable(error_condition_register) && !wr_flags |=> st_ff.flags[`CIF_BIT_ERR_CHG];
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("error change did not set summary flag");

  // without a flag write no set flag ever drops
  property p_flags_sticky;
    !wr_flags |=> ((st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags));
  endproperty
  a_flags_sticky: assert property (p_flags_sticky)
    else $error("flag cleared without a software write");

  // a flag write takes the data merged with same-cycle hardware sets
  property p_flags_write;
    wr_flags |=> (st_ff.flags == ($past(hwdata[7:0]) | $past(flag_set)));
  endproperty
  a_flags_write: assert property (p_flags_write)
    else $error("flag write result wrong");

  // reading the flag register returns it zero-extended
  property p_flags_read;
    (rd_sel == CIF_SEL_FLAGS) |=> (hrdata == {24'h00_0000, st_ff.flags});
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flag read data wrong");

  // receive full events with enable keep the interrupt for two cycles
  sequence s_rx_armed;
    (|(flag_set[`CIF_BIT_RX1:`CIF_BIT_RX0] & st_ff.enable[`CIF_BIT_RX1:`CIF_BIT_RX0]))
      && !wr_enable && !wr_flags;
  endsequence

  property p_rx_irq;
    s_rx_armed ##1 (!wr_enable && !wr_flags) |=> s_held_two;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive full event did not hold interrupt");

  // the output tracks pending enabled flags on every cycle
  property p_irq_level;
    irq == |(st_ff.flags & st_ff.enable);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with pending flags");

  // the slave never stretches a transfer and always answers okay
  property p_bus_ready;
    hreadyout && (hresp == `CIF_HRESP_OKAY);
  endproperty
  a_bus_ready: assert property (p_bus_ready)
    else $error("slave inserted wait state or error");

  // unmapped reads return zero
  property p_unmapped_read;
    (hsel && hready && htrans == `CIF_HTRANS_NONSEQ && !hwrite && rd_sel == CIF_SEL_NONE)
      |=> (hrdata == `CIF_RDATA_RST);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned nonzero data");

  // each source lands on its own flag bit
  property p_msg_err_flag;
    message_error_evt |=> st_ff.flags[`CIF_BIT_MSG_ERR];
  endproperty
  a_msg_err_flag: assert property (p_msg_err_flag)
    else $error("message error event did not set its flag");

  property p_wakeup_flag;
    wakeup_evt |=> st_ff.flags[`CIF_BIT_WAKEUP];
  endproperty
  a_wakeup_flag: assert property (p_wakeup_flag)
    else $error("wake-up event did not set its flag");

  // transmit buffer n maps to flag 2+n
  property p_tx_flags;
    (|tx_buf_empty_evt) |=>
      ((st_ff.flags[`CIF_BIT_TX2:`CIF_BIT_TX0] & $past(tx_buf_empty_evt)) == $past(tx_buf_empty_evt));
  endproperty
  a_tx_flags: assert property (p_tx_flags)
    else $error("transmit empty event set the wrong flag");

  // receive buffer n maps to flag n
  property p_rx_flags;
    (|rx_buf_full_evt) |=>
      ((st_ff.flags[`CIF_BIT_RX1:`CIF_BIT_RX0] & $past(rx_buf_full_evt)) == $past(rx_buf_full_evt));
  endproperty
  a_rx_flags: assert property (p_rx_flags)
    else $error("receive full event set the wrong flag");

  // hardware sets survive even a clearing write in the same cycle
  property p_flags_set;
    (|flag_set) |=> ((st_ff.flags & $past(flag_set)) == $past(flag_set));
  endproperty
  a_flags_set: assert property (p_flags_set)
    else $error("hardware set lost against software write");

  // a steady error level never raises the summary flag by itself
  property p_err_quiet;
    $past(hresetn) && $stable(error_condition_register) && !wr_flags && !st_ff.flags[`CIF_BIT_ERR_CHG]
      |=> !st_ff.flags[`CIF_BIT_ERR_CHG];
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("summary flag set without an error change");

  // only the error change pending and its enable clear: no interrupt
  property p_err_gated;
    (st_ff.flags == 8'h20) && !st_ff.enable[`CIF_BIT_ERR_CHG] |-> !irq;
  endproperty
  a_err_gated: assert property (p_err_gated)
    else $error("disabled error change raised interrupt");

  // the enable register only moves on a write
  property p_enable_hold;
    !wr_enable |=> $stable(st_ff.enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enable register changed without a write");

  property p_enable_read;
    (rd_sel == CIF_SEL_ENABLE) |=> (hrdata == {24'h00_0000, st_ff.enable});
  endproperty
  a_enable_read: assert property (p_enable_read)
    else $error("enable read data wrong");

  // clearing every flag with no event in flight drops the interrupt
  sequence s_clear_all;
    wr_flags && (hwdata[7:0] == 8'h00) && (flag_set == 8'h00);
  endsequence

  property p_clear_all;
    s_clear_all |=> (st_ff.flags == 8'h00) && !irq;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("clearing all flags left interrupt or flag set");

endmodule

`default_nettype wire

// ==== verif/test_can_interrupt_enable_flags.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cif_regs.svh"

module test_can_interrupt_enable_flags;
  localparam logic [31:0] ADDR_EN = {`CIF_IDX_ENABLE, 2'h0};
  localparam logic [31:0] ADDR_FL = {`CIF_IDX_FLAGS, 2'h0};
  localparam logic [31:0] ADDR_NONE = 32'h0000_0000;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0] ecr = 8'h00;
  logic msg_evt = 1'b0;
  logic wake_evt = 1'b0;
  logic [2:0] tx_evt = 3'h0;
  logic [1:0] rx_evt = 2'h0;
  wire hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  cif_irq_top cif_irq_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .error_condition_register(ecr),
    .message_error_evt(msg_evt), .wakeup_evt(wake_evt), .tx_buf_empty_evt(tx_evt),
    .rx_buf_full_evt(rx_evt), .irq(irq)
  );

  // ========================================================================
  // clock and watchdog
  // ========================================================================
  initial begin
    forever #25 hclk = ~hclk;
  end

  // generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    end_of_test();
  end

  // ========================================================================
  // compare and bus tasks
  // ========================================================================
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waits for ready sampled high at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      end_of_test();
    end
  endtask

  // called right after a rising edge; returns at the edge ending the data phase
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= `CIF_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk_bit(hresp, `CIF_HRESP_OKAY);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [7:0] d);
    logic [31:0] rd;
    xfer(1'b1, addr, {24'h00_0000, d}, rd);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [7:0] exp);
    logic [31:0] rd;
    xfer(1'b0, addr, 32'h0000_0000, rd);
    chk_reg(rd, {24'h00_0000, exp});
  endtask

  // irq is registered, so look one edge after the cause has landed
  task automatic chk_irq(input logic exp);
    @(posedge hclk);
    chk_bit(irq, exp);
  endtask

  // one-cycle event for flag position b; bit 5 is a change of the error level;
  // a quiet cycle follows so back-to-back calls never drive an input twice at one edge
  task automatic fire(input int b);
    case (b)
      7: msg_evt <= 1'b1;
      6: wake_evt <= 1'b1;
      5: ecr <= ecr ^ 8'h01;
      4, 3, 2: tx_evt[b-2] <= 1'b1;
      default: rx_evt[b] <= 1'b1;
    endcase
    @(posedge hclk);
    msg_evt <= 1'b0;
    wake_evt <= 1'b0;
    tx_evt <= 3'h0;
    rx_evt <= 2'h0;
    @(posedge hclk);
  endtask

  // ========================================================================
  // scenarios
  // ========================================================================
  task automatic t_reset_values();
    rd_chk(ADDR_EN, 8'h00);
    rd_chk(ADDR_FL, 8'h00);
    chk_bit(irq, 1'b0);
  endtask

  // both registers keep a written pattern; an unmapped write leaves the enable register untouched
  task automatic t_reg_access();
    wr(ADDR_EN, 8'ha5);
    wr(ADDR_FL, 8'h5a);
    rd_chk(ADDR_EN, 8'ha5);
    rd_chk(ADDR_FL, 8'h5a);
    chk_irq(1'b0);
    wr(ADDR_NONE, 8'hff);
    rd_chk(ADDR_NONE, 8'h00);
    rd_chk(ADDR_EN, 8'ha5);
    wr(ADDR_EN, 8'hff);
    chk_irq(1'b1);
    wr(ADDR_FL, 8'h00);
    rd_chk(ADDR_FL, 8'h00);
    chk_irq(1'b0);
  endtask

  // every source lands on its own flag and only its own enable lets it through
  task automatic t_sources();
    logic [7:0] m;
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      wr(ADDR_EN, ~m);
      fire(b);
      rd_chk(ADDR_FL, m);
      chk_irq(1'b0);
      wr(ADDR_EN, m);
      chk_irq(1'b1);
      wr(ADDR_FL, 8'h00);
      chk_irq(1'b0);
      fire(b);
      rd_chk(ADDR_FL, m);
      chk_bit(irq, 1'b1);
      wr(ADDR_FL, 8'h00);
    end
    wr(ADDR_EN, 8'h00);
  endtask

  // any error bit changing sets the summary flag; a steady level does not
  task automatic t_error_bits();
    for (int i = 0; i < 8; i++) begin
      ecr <= ecr ^ (8'h01 << i);
      @(posedge hclk);
      rd_chk(ADDR_FL, 8'h20);
      wr(ADDR_FL, 8'h00);
      repeat (3) @(posedge hclk);
      rd_chk(ADDR_FL, 8'h00);
    end
  endtask

  // flags hold until written zero; irq holds while any enabled flag remains
  task automatic t_sticky();
    wr(ADDR_EN, 8'h03);
    fire(0);
    fire(1);
    repeat (20) @(posedge hclk);
    chk_bit(irq, 1'b1);
    rd_chk(ADDR_FL, 8'h03);
    wr(ADDR_FL, 8'h02);
    rd_chk(ADDR_FL, 8'h02);
    chk_irq(1'b1);
    wr(ADDR_FL, 8'h00);
    chk_irq(1'b0);
  endtask

  // a clearing write and a receive event in one cycle: the event wins
  task automatic t_set_wins();
    hsel <= 1'b1;
    haddr <= ADDR_FL;
    htrans <= `CIF_HTRANS_NONSEQ;
    hwrite <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= 32'h0000_0000;
    rx_evt <= 2'h1;
    wait_rdy();
    rx_evt <= 2'h0;
    rd_chk(ADDR_FL, 8'h01);
    chk_bit(irq, 1'b1);
    wr(ADDR_FL, 8'h00);
    chk_irq(1'b0);
  endtask

  // ========================================================================
  // main sequence and verdict
  // ========================================================================
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_reg_access();
    t_sources();
    t_error_bits();
    t_sticky();
    t_set_wins();
    end_of_test();
  end
endmodule

`default_nettype wire
